// *** verilog/pr_pkg.sv ***
`default_nettype none
package pr_pkg;

  // clock and line rates; the bit enables are derived from these
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned LINE_RATE_HZ = 1_544_000;
  localparam int unsigned RATE_PPM     = 32;        // allowed line rate deviation
  localparam int unsigned NCO_W        = 32;
  // phase step per clock so that the accumulator wraps at the line bit rate
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((64'(LINE_RATE_HZ) << NCO_W) / 64'(CLK_HZ));

  // receive timing watchdog: four bit periods without a recovered edge
  localparam int unsigned BIT_CYC     = CLK_HZ / LINE_RATE_HZ;
  localparam int unsigned LOSS_BITS   = 4;
  localparam int unsigned LOSS_W      = 8;
  localparam logic [LOSS_W-1:0] RX_LOSS_CYC = LOSS_W'(BIT_CYC * LOSS_BITS);

  // eight-zero substitution layout, index 0 is sent first
  localparam int unsigned SUB_LEN  = 8;
  localparam int unsigned SUB_W    = 3;
  localparam logic [SUB_W-1:0] SUB_V1   = 3'h3;    // same polarity as last pulse
  localparam logic [SUB_W-1:0] SUB_B1   = 3'h4;    // opposite polarity
  localparam logic [SUB_W-1:0] SUB_B2   = 3'h6;    // opposite polarity
  localparam logic [SUB_W-1:0] SUB_V2   = 3'h7;    // same polarity, ends the pattern
  localparam logic [SUB_W-1:0] SUB_IDLE = 3'h0;

  // transmit data buffer
  localparam int unsigned FIFO_W     = 1;
  localparam int unsigned FIFO_DEPTH = 4;

  // one line symbol: a positive mark, a negative mark, or neither
  typedef struct packed {
    logic pos;
    logic neg;
  } pr_sym_t;

  localparam pr_sym_t SYM_ZERO = '{pos: 1'b0, neg: 1'b0};

  // transmit timing source
  typedef enum logic [1:0] {
    PR_TM_LOOP,
    PR_TM_LOCAL,
    PR_TM_REF
  } pr_timing_t;

endpackage : pr_pkg
`default_nettype wire

// *** verilog/pr_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module pr_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW:0]      wr_ptr_r, wr_ptr_nxt;
  logic [AW:0]      rd_ptr_r, rd_ptr_nxt;
  logic             full, empty, do_wr, do_rd;

  // extra pointer bit tells full from empty
  assign empty      = (wr_ptr_r == rd_ptr_r);
  assign full       = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign do_wr      = i_wr_valid && !full;
  assign do_rd      = i_rd_ready && !empty;
  assign o_rd_data  = mem_r[rd_ptr_r[AW-1:0]];   // storage is flip-flops

  // next pointers and storage
  always_comb begin
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (do_wr) begin
      mem_nxt[wr_ptr_r[AW-1:0]] = i_wr_data;
      wr_ptr_nxt                = wr_ptr_r + 1'b1;
    end
    if (do_rd) begin
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      mem_r    <= mem_nxt;
    end
  end

endmodule : pr_fifo
`default_nettype wire

// *** verilog/pr_line_coder.sv ***
`timescale 1ns/10ps
`default_nettype none
module pr_line_coder (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire pr_pkg::pr_timing_t i_timing_mode,
  input  wire logic               i_ref_tick,
  input  wire logic               i_tx_valid,
  input  wire logic               i_tx_data,
  output logic                    o_tx_ready,
  output pr_pkg::pr_sym_t         o_tx_line,
  output logic                    o_tx_tick,
  input  wire pr_pkg::pr_sym_t    i_rx_line,
  input  wire logic               i_rx_bclk,
  output logic                    o_rx_valid,
  output logic                    o_rx_data,
  output logic                    o_rx_sub,
  output logic                    o_rx_tick,
  output logic                    o_rx_lost
);
  import pr_pkg::*;

  // a mark of the given polarity
  function automatic pr_sym_t mark_sym(input logic pos);
    mark_sym = pos ? '{pos: 1'b1, neg: 1'b0} : '{pos: 1'b0, neg: 1'b1};
  endfunction : mark_sym

  // symbol of the substitution at position idx, referenced to the last pulse
  function automatic pr_sym_t sub_sym(input logic [SUB_W-1:0] idx, input logic last_pos);
    case (idx)
      SUB_V1, SUB_V2: sub_sym = mark_sym(last_pos);
      SUB_B1, SUB_B2: sub_sym = mark_sym(!last_pos);
      default:        sub_sym = SYM_ZERO;
    endcase
  endfunction : sub_sym

  // ---------------------------------------------------------------------------
  // receive pin synchronisers: two flops, then a third stage for the edge
  // ---------------------------------------------------------------------------
  logic    bclk_m_r, bclk_s_r, bclk_d_r;
  pr_sym_t rx_m_r, rx_s_r;
  logic    rx_edge;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bclk_m_r <= 1'b0;
      bclk_s_r <= 1'b0;
      bclk_d_r <= 1'b0;
      rx_m_r   <= SYM_ZERO;
      rx_s_r   <= SYM_ZERO;
    end else begin
      bclk_m_r <= i_rx_bclk;
      bclk_s_r <= bclk_m_r;
      bclk_d_r <= bclk_s_r;
      rx_m_r   <= i_rx_line;
      rx_s_r   <= rx_m_r;
    end
  end

  // data and clock share the same delay, so the symbol is taken at the rising edge;
  // no rate is assumed, which is what lets any rate within tolerance through
  assign rx_edge = bclk_s_r && !bclk_d_r;

  // ---------------------------------------------------------------------------
  // transmit timing: recovered edges, a reference tick, or a local NCO
  // ---------------------------------------------------------------------------
  logic [NCO_W-1:0]  nco_r, nco_nxt;
  logic              nco_tick;
  logic [LOSS_W-1:0] loss_cnt_r, loss_cnt_nxt;
  logic              lost_r, lost_nxt;
  logic              tx_tick;

  // the NCO is set to the nominal rate; its accuracy is that of i_clk
  assign nco_tick = (nco_nxt < nco_r);

  always_comb begin
    nco_nxt      = nco_r + NCO_INC;
    loss_cnt_nxt = loss_cnt_r;
    lost_nxt     = lost_r;
    if (rx_edge) begin
      loss_cnt_nxt = '0;
      lost_nxt     = 1'b0;
    end else if (loss_cnt_r == RX_LOSS_CYC) begin
      lost_nxt = 1'b1;
    end else begin
      loss_cnt_nxt = loss_cnt_r + 1'b1;
    end
  end

  // loop timing follows each recovered bit while lost_r is clear; the edge that clears lost_r still takes nco_tick;
  // while receive timing is gone the NCO keeps the line alive
  always_comb begin
    case (i_timing_mode)
      PR_TM_LOOP:  tx_tick = lost_r ? nco_tick : rx_edge;
      PR_TM_REF:   tx_tick = i_ref_tick;
      PR_TM_LOCAL: tx_tick = nco_tick;
      default:     tx_tick = nco_tick;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nco_r      <= '0;
      loss_cnt_r <= '0;
      lost_r     <= 1'b1;
    end else begin
      nco_r      <= nco_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      lost_r     <= lost_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // transmit data buffer; the encoder drains one bit per line tick
  // ---------------------------------------------------------------------------
  logic buf_valid;
  logic buf_data;
  logic in_bit;

  pr_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_wr_valid (i_tx_valid),
    .i_wr_data  (i_tx_data),
    .o_wr_ready (o_tx_ready),
    .o_rd_valid (buf_valid),
    .o_rd_data  (buf_data),
    .i_rd_ready (tx_tick)
  );

  // underrun sends zeros; long runs of them are covered by substitution
  assign in_bit = buf_valid && buf_data;

  // ---------------------------------------------------------------------------
  // encoder: eight-bit look-ahead window, oldest bit in bit 7
  // ---------------------------------------------------------------------------
  logic [SUB_LEN-1:0] win_r, win_nxt;
  logic [SUB_W-1:0]   sub_idx_r, sub_idx_nxt;
  logic               sub_pol_r, sub_pol_nxt;
  logic               last_pos_r, last_pos_nxt;
  pr_sym_t            tx_sym_r, tx_sym_nxt;
  logic               tx_tick_r;
  pr_sym_t            sym;

  always_comb begin
    win_nxt      = win_r;
    sub_idx_nxt  = sub_idx_r;
    sub_pol_nxt  = sub_pol_r;
    last_pos_nxt = last_pos_r;
    tx_sym_nxt   = tx_sym_r;
    sym          = SYM_ZERO;
    if (tx_tick) begin
      if (sub_idx_r != SUB_IDLE) begin
        // pattern in progress; the polarity reference is frozen at its start
        sym         = sub_sym(sub_idx_r, sub_pol_r);
        sub_idx_nxt = sub_idx_r + 1'b1;               // wraps to idle after the last
      end else if (win_r == '0) begin
        // eight zeros are about to go out: replace them
        sym         = sub_sym(SUB_IDLE, last_pos_r);
        sub_pol_nxt = last_pos_r;
        sub_idx_nxt = SUB_IDLE + 1'b1;
      end else if (win_r[SUB_LEN-1]) begin
        sym = mark_sym(!last_pos_r);
      end
      // any pulse sent, substituted or not, is the new reference
      if (sym.pos || sym.neg) begin
        last_pos_nxt = sym.pos;
      end
      win_nxt    = {win_r[SUB_LEN-2:0], in_bit};
      tx_sym_nxt = sym;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      win_r      <= '1;             // the eight reset bits go out as marks, not as a substitution
      sub_idx_r  <= SUB_IDLE;
      sub_pol_r  <= 1'b0;
      last_pos_r <= 1'b0;           // first mark goes out positive
      tx_sym_r   <= SYM_ZERO;
      tx_tick_r  <= 1'b0;
    end else begin
      win_r      <= win_nxt;
      sub_idx_r  <= sub_idx_nxt;
      sub_pol_r  <= sub_pol_nxt;
      last_pos_r <= last_pos_nxt;
      tx_sym_r   <= tx_sym_nxt;
      tx_tick_r  <= tx_tick;
    end
  end

  assign o_tx_line = tx_sym_r;
  assign o_tx_tick = tx_tick_r;

  // ---------------------------------------------------------------------------
  // decoder: eight symbols of history, newest in slot 0, bits delayed to match
  // ---------------------------------------------------------------------------
  pr_sym_t            hist_r [SUB_LEN];
  pr_sym_t            hist_nxt [SUB_LEN];
  logic [SUB_LEN-1:0] bits_r, bits_nxt;
  logic               prev_pos_r, prev_pos_nxt;
  logic               rx_data_r, rx_data_nxt;
  logic               rx_valid_r, rx_sub_r, rx_tick_r;
  logic               hit;
  logic               v_pos;
  pr_sym_t            smp;

  // a symbol with both marks is read as positive
  assign smp = rx_s_r.pos ? mark_sym(1'b1) : (rx_s_r.neg ? mark_sym(1'b0) : SYM_ZERO);

  always_comb begin
    hist_nxt     = hist_r;
    bits_nxt     = bits_r;
    prev_pos_nxt = prev_pos_r;
    rx_data_nxt  = rx_data_r;
    hit          = 1'b0;
    v_pos        = 1'b0;
    if (rx_edge) begin
      // the symbol leaving the window becomes the polarity reference
      if (hist_r[SUB_LEN-1].pos || hist_r[SUB_LEN-1].neg) begin
        prev_pos_nxt = hist_r[SUB_LEN-1].pos;
      end
      rx_data_nxt = bits_r[SUB_LEN-1];
      for (int i = SUB_LEN - 1; i > 0; i--) begin
        hist_nxt[i] = hist_r[i-1];
      end
      hist_nxt[0] = smp;
      bits_nxt    = {bits_r[SUB_LEN-2:0], smp.pos || smp.neg};
      // both violations must repeat the preceding polarity, oldest slot first
      v_pos = prev_pos_nxt;
      hit   = (hist_nxt[7] == SYM_ZERO) && (hist_nxt[6] == SYM_ZERO) &&
              (hist_nxt[5] == SYM_ZERO) && (hist_nxt[4] == mark_sym(v_pos)) &&
              (hist_nxt[3] == mark_sym(!v_pos)) && (hist_nxt[2] == SYM_ZERO) &&
              (hist_nxt[1] == mark_sym(!v_pos)) && (hist_nxt[0] == mark_sym(v_pos));
      if (hit) begin
        bits_nxt = '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < SUB_LEN; i++) begin
        hist_r[i] <= SYM_ZERO;
      end
      bits_r     <= '0;
      prev_pos_r <= 1'b0;
      rx_data_r  <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_sub_r   <= 1'b0;
      rx_tick_r  <= 1'b0;
    end else begin
      hist_r     <= hist_nxt;
      bits_r     <= bits_nxt;
      prev_pos_r <= prev_pos_nxt;
      rx_data_r  <= rx_data_nxt;
      rx_valid_r <= rx_edge;
      rx_sub_r   <= hit;
      rx_tick_r  <= rx_edge;
    end
  end

  // the recovered tick is offered to other interfaces as a common source
  assign o_rx_valid = rx_valid_r;
  assign o_rx_data  = rx_data_r;
  assign o_rx_sub   = rx_sub_r;
  assign o_rx_tick  = rx_tick_r;
  assign o_rx_lost  = lost_r;

endmodule : pr_line_coder
`default_nettype wire

// *** verification/pr_line_coder_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module pr_line_coder_monitor (
  input wire logic               i_clk,
  input wire logic               i_nrst,
  input wire pr_pkg::pr_timing_t i_timing_mode,
  input wire logic               i_ref_tick,
  input wire logic               i_rx_bclk,
  input wire pr_pkg::pr_sym_t    o_tx_line,
  input wire logic               o_tx_tick,
  input wire logic               o_rx_valid,
  input wire logic               o_rx_sub,
  input wire logic               o_rx_tick,
  input wire logic               o_rx_lost
);
  import pr_pkg::*;
  logic [3:0] zcnt_r, zcnt_nxt;
  logic [6:0] quiet_r, quiet_nxt;
  logic       last_pos_r, last_pos_nxt, bclk_r, mark, same_pol;
  // space run and last pulse polarity, looked at only on transmit ticks
  always_comb begin
    mark         = o_tx_line.pos | o_tx_line.neg;
    same_pol     = mark && (o_tx_line.pos == last_pos_r);
    zcnt_nxt     = zcnt_r;
    last_pos_nxt = last_pos_r;
    quiet_nxt    = (i_rx_bclk != bclk_r) ? 7'h0 : quiet_r + {6'h0, quiet_r != 7'h7f};
    if (o_tx_tick) begin
      zcnt_nxt     = mark ? 4'h0 : zcnt_r + {3'h0, zcnt_r != 4'hf};
      last_pos_nxt = mark ? o_tx_line.pos : last_pos_r;
    end
  end
  // reference polarity starts negative, so the first mark must be positive
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      zcnt_r     <= 4'h0;
      quiet_r    <= 7'h0;
      last_pos_r <= 1'b0;
      bclk_r     <= 1'b0;
    end else begin
      zcnt_r     <= zcnt_nxt;
      quiet_r    <= quiet_nxt;
      last_pos_r <= last_pos_nxt;
      bclk_r     <= i_rx_bclk;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence rx_edge_s;
    $rose(i_rx_bclk);
  endsequence
  // loop timing only counts once the receive side is not flagged lost
  sequence loop_edge_s;
    rx_edge_s ##0 ((i_timing_mode == PR_TM_LOOP) && !o_rx_lost);
  endsequence
  rx_tick_a: assert property (o_rx_tick |-> $past(i_rx_bclk, 3) && !$past(i_rx_bclk, 4)) else $error("rx tick off edge");
  sub_valid_a: assert property (o_rx_sub |-> o_rx_valid) else $error("sub without valid");
  line_tick_a: assert property ($changed(o_tx_line) |-> o_tx_tick) else $error("line moved off tick");
  one_pol_a: assert property (!(o_tx_line.pos && o_tx_line.neg)) else $error("both polarities");
  viol_place_a: assert property (o_tx_tick && same_pol |-> zcnt_r == 4'h3 || zcnt_r == 4'h1)
    else $error("violation out of place");
  space_run_a: assert property (zcnt_r < 4'h8) else $error("eight spaces sent");
  rx_answer_a: assert property (rx_edge_s |-> ##[2:6] o_rx_valid) else $error("no rx valid");
  loop_tick_a: assert property (loop_edge_s |-> ##[2:6] o_tx_tick) else $error("no loop tick");
  ref_tick_a: assert property (i_timing_mode == PR_TM_REF && i_ref_tick |-> ##[0:2] o_tx_tick)
    else $error("no ref tick");
  lost_set_a: assert property (quiet_r >= 7'h48 |-> o_rx_lost) else $error("lost not raised");
endmodule : pr_line_coder_monitor
bind pr_line_coder pr_line_coder_monitor i_pr_line_coder_monitor (
  .i_clk, .i_nrst, .i_timing_mode, .i_ref_tick, .i_rx_bclk, .o_tx_line,
  .o_tx_tick, .o_rx_valid, .o_rx_sub, .o_rx_tick, .o_rx_lost
);
`default_nettype wire

// *** verification/pr_far_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module pr_far_end (
  input  wire logic       i_clk,
  output pr_pkg::pr_sym_t o_line,
  output logic            o_bclk
);
  import pr_pkg::*;
  initial begin
    o_line = SYM_ZERO;
    o_bclk = 1'b0;
  end
  // one bit period: symbol and clock rise together; half sets the pace
  task automatic send(input pr_sym_t s, input int half);
    o_line <= s;
    o_bclk <= 1'b1;
    repeat (half) @(posedge i_clk);
    o_bclk <= 1'b0;
    repeat (half) @(posedge i_clk);
  endtask : send
  // a released pair must not echo the last symbol
  task automatic release_line();
    o_line <= pr_sym_t'(~o_line);
  endtask : release_line
endmodule : pr_far_end
`default_nettype wire

// *** verification/tb_pr_line_coder.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_pr_line_coder;
  import pr_pkg::*;
  logic        i_clk, i_nrst, i_ref_tick, i_tx_valid, i_tx_data, i_rx_bclk, counting;
  logic        o_tx_ready, o_tx_tick, o_rx_valid, o_rx_data, o_rx_sub, o_rx_tick, o_rx_lost;
  pr_timing_t  i_timing_mode;
  pr_sym_t     i_rx_line, o_tx_line;
  logic [63:0] rx_seen;
  int          errors, num_checks, tx_ticks, rx_subs;

  pr_line_coder i_pr_line_coder (
    .i_clk, .i_nrst, .i_timing_mode, .i_ref_tick, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_tx_line,
    .o_tx_tick, .i_rx_line, .i_rx_bclk, .o_rx_valid, .o_rx_data, .o_rx_sub, .o_rx_tick, .o_rx_lost
  );
  pr_far_end i_pr_far_end (.i_clk, .o_line(i_rx_line), .o_bclk(i_rx_bclk));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // collect decoded bits and tick counts; registered outputs read pre-edge
  always @(posedge i_clk) begin
    if (o_rx_valid === 1'b1) rx_seen = {rx_seen[62:0], o_rx_data};
    if (o_rx_sub === 1'b1) rx_subs++;
    if (counting && o_tx_tick === 1'b1) tx_ticks++;
  end

  function automatic pr_sym_t sym_of(input byte c);
    return pr_sym_t'({c == "p", c == "n"});
  endfunction : sym_of
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // offer one bit; ok says whether the buffer should have room
  task automatic push(input logic b, input logic ok);
    @(posedge i_clk);
    i_tx_valid <= 1'b1;
    i_tx_data  <= b;
    #1 check(o_tx_ready, ok);
    @(posedge i_clk);
    i_tx_valid <= 1'b0;
  endtask : push
  // no ticks in reference mode, so four spaces fill the buffer and a fifth is turned away
  task automatic test_fill();
    for (int k = 0; k < 4; k++) push(1'b0, 1'b1);
    push(1'b0, 1'b0);
  endtask : test_fill
  // each reference tick sends one symbol; the buffer is topped up after each of the first 14
  task automatic test_tx();
    string exp;
    string bits;
    logic  got;
    exp  = "pnpnpnpn000np0pnp000pn0npn";
    bits = "000000001000000001";
    for (int i = 0; i < 26; i++) begin
      got = 1'b0;
      @(posedge i_clk);
      i_ref_tick <= 1'b1;
      @(posedge i_clk);
      i_ref_tick <= 1'b0;
      repeat (3) begin
        #1;
        if (!got && o_tx_tick === 1'b1) begin
          got = 1'b1;
          check(o_tx_line, sym_of(exp[i]));
        end
        @(posedge i_clk);
      end
      check(got, 1'b1);
      if (i < 14) push(bits[i + 4] == "1", 1'b1);
    end
  endtask : test_tx
  // both substitutions, a bare space run, then a flush; transmit follows rx
  task automatic test_rx();
    string s;
    s = "p000pn0npn000np0pnp00000000npnpnpnp";
    check(o_rx_lost, 1'b1);
    i_timing_mode <= PR_TM_LOOP;
    rx_subs  = 0;
    tx_ticks = 0;
    for (int i = 0; i < 35; i++) begin
      counting <= (i >= 4);
      i_pr_far_end.send(sym_of(s[i]), 3);
    end
    counting <= 1'b0;
    i_pr_far_end.release_line();
    repeat (8) @(posedge i_clk);
    check(rx_seen[34:0], 35'h402_0100);
    check(rx_subs, 2);
    check(tx_ticks, 31);
    repeat (72) @(posedge i_clk);
    check(o_rx_lost, 1'b1);
    // receive timing gone: loop mode must fall back to the local rate, not stall
    tx_ticks = 0;
    counting <= 1'b1;
    repeat (100) @(posedge i_clk);
    counting <= 1'b0;
    check(tx_ticks >= 6 && tx_ticks <= 7, 1'b1);
  endtask : test_rx
  // free-running timing over one millisecond of clocks
  task automatic test_rate();
    i_timing_mode <= PR_TM_LOCAL;
    repeat (4) @(posedge i_clk);
    tx_ticks = 0;
    counting <= 1'b1;
    repeat (25000) @(posedge i_clk);
    counting <= 1'b0;
    check(tx_ticks >= 1543 && tx_ticks <= 1545, 1'b1);
  endtask : test_rate

  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    conclude();
  end
  initial begin
    i_nrst        = 1'b0;
    i_ref_tick    = 1'b0;
    i_tx_valid    = 1'b0;
    i_tx_data     = 1'b0;
    i_timing_mode = PR_TM_REF;
    counting      = 1'b0;
    rx_seen       = '0;
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    test_fill();
    test_tx();
    test_rx();
    test_rate();
    conclude();
  end
endmodule : tb_pr_line_coder
`default_nettype wire
